// ### verilog/ebm_regs.svh
// constants of the external bus master: beat counts, depths, field positions
// Contract
// R1 - start an external cycle only with grant asserted and the busy line negated.
// R2 - keep bus request asserted while a cycle waits without a qualified grant.
// R3 - on a qualified grant assert busy first, then start the address phase.
// R4 - a new owner waits until the current owner negates the busy line.
// R5 - split a word access to a 16-bit port into two cycles, bus held.
// R6 - arbiter may park the bus by holding grant; single master ties grant low.
// R7 - never more than two addresses outstanding on the bus.
// R8 - start a write only when the pipe is, or would fall to, zero.
// R9 - start a read when the pipe is, or would fall to, zero or one.
// R10 - address type: first bit supervisor, second bit instruction.
// R11 - 32-bit port: four lane selects enable byte lanes zero to three in order.
// R12 - 16-bit port: lanes zero and one, then address bit 30, then operand size.
// R13 - each cycle is address then data phase, arbitration only when bus not held.
// R14 - a burst cycle moves four data words.
// R15 - one grant covers address and data buses together.
// R16 - drive a new address at address phase start and hold it throughout.
// R17 - at address phase start drive address, start, direction, lanes, type, kind, burst.
// R18 - every bus signal launched and sampled on the rising bus clock edge.
// R19 - while reset input is asserted the reset indication output is asserted.
// R20 - watchers of the reset indication reset their software-resettable parts.
// R21 - outside logic drives a level cancel-reservation input, one per processor.
// R22 - the arbiter has a separate grant and request for each master.
// R23 - transfer start is asserted for exactly one bus clock per access.
// R24 - address phase ends on address ack, address retry or error ack.
// R25 - data phase starts one clock after address phase, or after the earlier one.
// R26 - release busy after the last owned cycle unless a locked split remains.
`ifndef EBM_REGS_SVH
`define EBM_REGS_SVH

`define EBM_BURST_BEATS  3'h4
`define EBM_SINGLE_BEATS 3'h1
`define EBM_MAX_DEPTH    2'h2
`define EBM_AT_SUPER     1
`define EBM_AT_INSTR     0
`define EBM_LANE_ADDR30  2
`define EBM_LANE_SIZE    3
`define EBM_IDLE_PINS    7'h7F

`endif

// ### verilog/ebm_pkg.sv
// types shared by the external bus master modules
package ebm_pkg;

	typedef enum logic [1:0] {
		EBM_SZ_BYTE = 2'h0,
		EBM_SZ_HALF = 2'h1,
		EBM_SZ_WORD = 2'h2
	} ebm_size_t;

	typedef enum {
		ST_IDLE,
		ST_REQ,
		ST_LEAD,
		ST_ADDR
	} ebm_state_t;

endpackage : ebm_pkg

// ### verilog/ebm_pipe_if.sv
// carrier between the bus sequencer and the pipeline depth tracker
interface ebm_pipe_if;
	logic       tick;
	logic       ta;
	logic       bus_error_ack;
	logic       push;
	logic [2:0] push_beats;
	logic       retry;
	logic       done;
	logic       done_err;
	logic [1:0] depth;
	logic       can_read;
	logic       can_write;

	modport tracker (input tick, ta, bus_error_ack, push, push_beats, retry,
		output done, done_err, depth, can_read, can_write);
	modport ctrl (output tick, ta, bus_error_ack, push, push_beats, retry,
		input done, done_err, depth, can_read, can_write);
endinterface : ebm_pipe_if

// ### verilog/ebm_sync.sv
// two-stage synchroniser for bus pins
module ebm_sync #(
	parameter int              W    = 7,
	parameter logic [W-1:0]    INIT = '1
) (
	input  wire logic         clk_in,
	input  wire logic         resetn_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	logic [W-1:0] meta_reg;

	// first stage feeds only the second
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			meta_reg <= INIT;
			q_out    <= INIT;
		end else begin
			meta_reg <= d_in;
			q_out    <= meta_reg;
		end
	end
endmodule // ebm_sync

// ### verilog/ebm_pipe.sv
// pipeline depth tracker: outstanding addresses and their data beats
`include "ebm_regs.svh"

module ebm_pipe
	import ebm_pkg::*;
(
	input  wire logic   clk_in,
	input  wire logic   resetn_in,
	ebm_pipe_if.tracker pif
);
	logic [1:0] depth_reg;
	logic [2:0] beats0_reg;
	logic [2:0] beats1_reg;
	logic       done_raw;
	logic       rm_head;
	logic [1:0] after;
	logic [2:0] beats0_next;
	logic [2:0] beats1_next;

	// head data phase ends on its last beat or on an error ack
	always_comb begin
		done_raw = pif.tick && (depth_reg != 2'h0) && (pif.bus_error_ack || (pif.ta && beats0_reg == 3'h1)); // [R25]
		rm_head  = done_raw && !(pif.retry && depth_reg == 2'h1);
		after    = 2'(depth_reg - 2'(rm_head) - 2'(pif.retry));
	end

	assign pif.done      = rm_head;
	assign pif.done_err  = pif.bus_error_ack;
	assign pif.depth     = depth_reg;
	assign pif.can_write = (after == 2'h0); // [R8]
	assign pif.can_read  = (after <= 2'h1); // [R9]

	always_comb begin
		beats0_next = beats0_reg;
		beats1_next = beats1_reg;
		if (pif.tick && pif.ta && !done_raw && depth_reg != 2'h0)
			beats0_next = 3'(beats0_reg - 3'h1); // [R14]
		if (rm_head)
			beats0_next = beats1_reg;
		if (pif.push) begin
			if (after == 2'h0)
				beats0_next = pif.push_beats;
			else
				beats1_next = pif.push_beats;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			depth_reg  <= 2'h0;
			beats0_reg <= 3'h0;
			beats1_reg <= 3'h0;
		end else begin
			depth_reg  <= 2'(after + 2'(pif.push)); // [R7]
			beats0_reg <= beats0_next;
			beats1_reg <= beats1_next;
		end
	end

	a_depth_bound: assert property (@(posedge clk_in) disable iff (!resetn_in) // [R7]
		depth_reg <= `EBM_MAX_DEPTH)
		else $error("pipe depth above two");
endmodule // ebm_pipe

// ### verilog/ebm_master.sv
// external bus master: arbitration, address phase launch and pipeline control
`include "ebm_regs.svh"

module ebm_master
	import ebm_pkg::*;
#(
	parameter int ADDR_W = 32,
	parameter int CK_W   = 4
) (
	input  wire logic              clk_in,
	input  wire logic              resetn_in,
	input  wire logic              req_valid_in,
	output logic                   req_ready_out,
	input  wire logic [ADDR_W-1:0] req_addr_in,
	input  wire logic              req_write_in,
	input  wire ebm_size_t         req_size_in,
	input  wire logic              req_port16_in,
	input  wire logic              req_super_in,
	input  wire logic              req_instr_in,
	input  wire logic              req_burst_in,
	input  wire logic [CK_W-1:0]   req_cycle_kind_in,
	output logic                   resp_valid_out,
	output logic                   resp_error_out,
	output logic                   reservation_none_out,
	output logic                   bus_clock_output_out,
	output logic                   reset_indication_n_out,
	output logic                   bus_request_n_out,
	input  wire logic              bus_grant_n_in,
	input  wire logic              bus_busy_line_n_in,
	output logic                   bus_busy_line_n_out,
	output logic                   bus_busy_line_oe_out,
	output logic [ADDR_W-3:0]      addr_out,
	output logic                   transfer_begin_n_out,
	output logic                   write_out,
	output logic [3:0]             lane_select_n_out,
	output logic [1:0]             address_space_type_out,
	output logic [CK_W-1:0]        cycle_kind_out,
	output logic                   burst_n_out,
	input  wire logic              addr_phase_ack_n_in,
	input  wire logic              addr_phase_retry_n_in,
	input  wire logic              bus_error_ack_n_in,
	input  wire logic              beat_acknowledge_n_in,
	input  wire logic              cancel_reservation_n_in
);

	// ****************************************
	// declarations
	// ****************************************
	ebm_state_t        st_reg;
	logic [6:0]        pin_sync;
	logic              tick;
	logic              grant;
	logic              others_busy;
	logic              addr_phase_ack;
	logic              retry;
	logic              bus_error_ack;
	logic              ta;
	logic              qualified;
	logic              allowed;
	logic              start;
	logic              addr_end;
	logic              own_reg;
	logic              pend_reg;
	logic              lock_reg;
	logic              half2_reg;
	logic [ADDR_W-1:0] cur_addr_reg;
	logic              cur_write_reg;
	ebm_size_t         cur_size_reg;
	logic              cur_port16_reg;
	logic              cur_super_reg;
	logic              cur_instr_reg;
	logic              cur_burst_reg;
	logic [CK_W-1:0]   cur_kind_reg;
	logic              accept;

	ebm_pipe_if pif ();

	// ****************************************
	// lane select encoding
	// ****************************************
	// index 0 is the lane of the most significant byte
	function automatic logic [3:0] ebm_lanes(input ebm_size_t sz, input logic [1:0] a,
		input logic p16, input logic h2);
		logic [3:0] en;
		en = 4'h0;
		if (p16) begin
			unique case (sz)
				EBM_SZ_WORD: en[1:0] = 2'h3;
				EBM_SZ_HALF: en[1:0] = 2'h3;
				default:     en[a[0]] = 1'b1;
			endcase
			en[`EBM_LANE_ADDR30] = (sz == EBM_SZ_WORD) ? h2 : a[1]; // [R12]
			en[`EBM_LANE_SIZE]   = (sz != EBM_SZ_WORD); // [R12]
		end else begin
			unique case (sz)
				EBM_SZ_WORD: en = 4'hF; // [R11]
				EBM_SZ_HALF: en = a[1] ? 4'hC : 4'h3; // [R11]
				default:     en[a] = 1'b1; // [R11]
			endcase
		end
		return en;
	endfunction

	// ****************************************
	// pins, bus clock and reset indication
	// ****************************************
	ebm_sync #(
		.W    (7),
		.INIT (`EBM_IDLE_PINS)
	) u_sync (
		.clk_in    (clk_in),
		.resetn_in (resetn_in),
		.d_in      ({bus_grant_n_in, bus_busy_line_n_in, addr_phase_ack_n_in, addr_phase_retry_n_in,
		             bus_error_ack_n_in, beat_acknowledge_n_in, cancel_reservation_n_in}),
		.q_out     (pin_sync)
	);

	assign grant       = !pin_sync[6];
	assign others_busy = !pin_sync[5];
	assign addr_phase_ack        = !pin_sync[4];
	assign retry       = !pin_sync[3];
	assign bus_error_ack         = !pin_sync[2];
	assign ta          = !pin_sync[1];

	// bus clock runs at half the core rate; the bus pins move on its rising edge
	assign tick = !bus_clock_output_out; // [R18]

	always_ff @(posedge clk_in) begin
		if (!resetn_in)
			bus_clock_output_out <= 1'b0;
		else
			bus_clock_output_out <= !bus_clock_output_out; // [R18]
	end

	always_ff @(posedge clk_in) begin
		if (!resetn_in)
			reset_indication_n_out <= 1'b0; // [R19]
		else
			reset_indication_n_out <= 1'b1;
	end

	always_ff @(posedge clk_in) begin
		if (!resetn_in)
			reservation_none_out <= 1'b0;
		else
			reservation_none_out <= !pin_sync[0]; // [R21]
	end

	// ****************************************
	// pipeline tracker
	// ****************************************
	assign pif.tick       = tick;
	assign pif.ta         = ta;
	assign pif.bus_error_ack        = bus_error_ack;
	assign pif.push       = start;
	assign pif.push_beats = cur_burst_reg ? `EBM_BURST_BEATS : `EBM_SINGLE_BEATS; // [R14]
	assign pif.retry      = addr_end && retry && !bus_error_ack;

	ebm_pipe u_pipe (
		.clk_in    (clk_in),
		.resetn_in (resetn_in),
		.pif       (pif)
	);

	// ****************************************
	// sequencing
	// ****************************************
	// our own busy drive would mask a stale grant, so qualify only while not owner
	assign qualified = grant && !others_busy; // [R1]
	assign allowed   = cur_write_reg ? pif.can_write : pif.can_read; // [R8] [R9]
	assign start     = tick && pend_reg && own_reg && allowed
		&& (st_reg == ST_IDLE || st_reg == ST_LEAD); // [R13]
	assign addr_end  = tick && st_reg == ST_ADDR && (addr_phase_ack || retry || bus_error_ack); // [R24]
	assign accept    = req_valid_in && req_ready_out;

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			st_reg <= ST_IDLE;
		end else if (tick) begin
			unique case (st_reg)
				ST_IDLE: begin
					if (start)
						st_reg <= ST_ADDR;
					else if (pend_reg && !own_reg)
						st_reg <= ST_REQ; // [R13]
				end
				ST_REQ: begin
					if (qualified)
						st_reg <= ST_LEAD; // [R3]
				end
				ST_LEAD: begin
					if (start)
						st_reg <= ST_ADDR; // [R3]
				end
				ST_ADDR: begin
					if (addr_end)
						st_reg <= ST_IDLE; // [R24]
				end
			endcase
		end
	end

	// one grant owns address and data buses together
	always_ff @(posedge clk_in) begin
		if (!resetn_in)
			own_reg <= 1'b0;
		else if (tick && st_reg == ST_REQ && qualified)
			own_reg <= 1'b1; // [R3] [R15]
		else if (pif.retry)
			own_reg <= 1'b0;
		else if (tick && st_reg == ST_IDLE && !pend_reg && pif.depth == 2'h0 && !pif.done)
			own_reg <= 1'b0; // [R26]
	end

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			bus_busy_line_n_out  <= 1'b1;
			bus_busy_line_oe_out <= 1'b0;
		end else if (tick) begin
			// taken at the grant tick so busy leads transfer start by a bus clock
			bus_busy_line_n_out  <= !(own_reg || (st_reg == ST_REQ && qualified));
			bus_busy_line_oe_out <= own_reg || (st_reg == ST_REQ && qualified); // [R3] [R26] [R18]
		end
	end

	always_ff @(posedge clk_in) begin
		if (!resetn_in)
			bus_request_n_out <= 1'b1;
		else if (tick)
			bus_request_n_out <= !((st_reg == ST_IDLE && pend_reg && !own_reg)
				|| (st_reg == ST_REQ && !qualified)); // [R2] [R18]
	end

	// ****************************************
	// request capture and split word handling
	// ****************************************
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			pend_reg      <= 1'b0;
			req_ready_out <= 1'b1;
			lock_reg      <= 1'b0;
			half2_reg     <= 1'b0;
		end else if (accept) begin
			pend_reg      <= 1'b1;
			req_ready_out <= 1'b0;
			half2_reg     <= 1'b0;
			lock_reg      <= req_port16_in && req_size_in == EBM_SZ_WORD; // [R5]
		end else if (addr_end && !bus_error_ack && !retry && addr_phase_ack && lock_reg && !half2_reg) begin
			half2_reg     <= 1'b1; // [R5]
		end else if (addr_end && (bus_error_ack || (addr_phase_ack && !retry))) begin
			pend_reg      <= 1'b0;
			req_ready_out <= 1'b1;
			lock_reg      <= 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			cur_addr_reg   <= '0;
			cur_write_reg  <= 1'b0;
			cur_size_reg   <= EBM_SZ_WORD;
			cur_port16_reg <= 1'b0;
			cur_super_reg  <= 1'b0;
			cur_instr_reg  <= 1'b0;
			cur_burst_reg  <= 1'b0;
			cur_kind_reg   <= '0;
		end else if (accept) begin
			cur_addr_reg   <= req_addr_in;
			cur_write_reg  <= req_write_in;
			cur_size_reg   <= req_size_in;
			cur_port16_reg <= req_port16_in;
			cur_super_reg  <= req_super_in;
			cur_instr_reg  <= req_instr_in;
			cur_burst_reg  <= req_burst_in;
			cur_kind_reg   <= req_cycle_kind_in;
		end
	end

	// ****************************************
	// address phase launch
	// ****************************************
	// attributes stay until the next start so slaves may sample late
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			addr_out               <= '0;
			write_out              <= 1'b0;
			lane_select_n_out      <= 4'hF;
			address_space_type_out <= 2'h0;
			cycle_kind_out         <= '0;
			burst_n_out            <= 1'b1;
		end else if (start) begin
			addr_out               <= cur_addr_reg[ADDR_W-1:2]; // [R16] [R17]
			write_out              <= cur_write_reg; // [R17]
			lane_select_n_out      <= ~ebm_lanes(cur_size_reg, cur_addr_reg[1:0], cur_port16_reg, half2_reg);
			address_space_type_out[`EBM_AT_SUPER] <= cur_super_reg; // [R10]
			address_space_type_out[`EBM_AT_INSTR] <= cur_instr_reg; // [R10]
			cycle_kind_out         <= cur_kind_reg; // [R17]
			burst_n_out            <= !cur_burst_reg; // [R17]
		end
	end

	always_ff @(posedge clk_in) begin
		if (!resetn_in)
			transfer_begin_n_out <= 1'b1;
		else if (start)
			transfer_begin_n_out <= 1'b0; // [R23]
		else if (tick)
			transfer_begin_n_out <= 1'b1; // [R23]
	end

	// ****************************************
	// completion to the user
	// ****************************************
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			resp_valid_out <= 1'b0;
			resp_error_out <= 1'b0;
		end else begin
			resp_valid_out <= pif.done || (addr_end && bus_error_ack && pif.depth == 2'h0);
			resp_error_out <= tick && pif.done_err;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);

	sequence s_ts_pulse;
		!transfer_begin_n_out [*2] ##1 transfer_begin_n_out;
	endsequence

	sequence s_busy_then_ts;
		!bus_busy_line_n_out && bus_busy_line_oe_out ##1 $fell(transfer_begin_n_out);
	endsequence

	a_start_owned: assert property ( // [R1]
		$fell(transfer_begin_n_out) |-> own_reg && $past(own_reg))
		else $error("transfer start without bus ownership");

	a_busy_before_ts: assert property ( // [R3]
		$fell(transfer_begin_n_out) |-> $past(bus_busy_line_oe_out) && $past(!bus_busy_line_n_out))
		else $error("busy line not driven before transfer start");

	a_request_held: assert property ( // [R2]
		st_reg == ST_REQ && !qualified && tick |=> !bus_request_n_out)
		else $error("bus request dropped while waiting for grant");

	a_ts_one_bus_clk: assert property ( // [R23]
		$fell(transfer_begin_n_out) |-> s_ts_pulse)
		else $error("transfer start not one bus clock long");

	a_write_alone: assert property ( // [R8]
		$fell(transfer_begin_n_out) && write_out |-> pif.depth == 2'h1)
		else $error("write started with cycles outstanding");

	a_addr_stable: assert property ( // [R16]
		st_reg == ST_ADDR && $past(st_reg) == ST_ADDR |-> $stable(addr_out) && $stable(lane_select_n_out))
		else $error("address changed during address phase");

	a_space_type: assert property ( // [R10]
		$fell(transfer_begin_n_out) |-> address_space_type_out == {cur_super_reg, cur_instr_reg})
		else $error("address type encoding wrong");

	a_split_locked: assert property ( // [R5]
		lock_reg && half2_reg |-> bus_busy_line_oe_out || $past(pif.retry, 2))
		else $error("bus released inside split word access");

	a_reset_mirror: assert property (@(posedge clk_in) disable iff (1'b0) // [R19]
		!resetn_in |=> !reset_indication_n_out)
		else $error("reset indication not asserted in reset");

	a_busy_leads: assert property ( // [R3]
		st_reg == ST_LEAD && tick && start |-> s_busy_then_ts)
		else $error("address phase began without busy");

endmodule // ebm_master

// ### test/ebm_bus_model.sv
// far-side model: central arbiter, one rival master and a pipelined slave
module ebm_bus_model (
	input  wire logic       clk_in,
	input  wire logic       resetn_in,
	input  wire logic       tick_in,
	input  wire logic       ts_n_in,
	input  wire logic       burst_n_in,
	input  wire logic       write_in,
	input  wire logic       hold_in,
	input  wire logic       err_in,
	input  wire logic       slow_in,
	input  wire logic [1:0] ack_dly_in,
	output logic            grant_n_out,
	output logic            other_bb_out,
	output logic            addr_phase_ack_n_out,
	output logic            tea_n_out,
	output logic            ta_n_out,
	output logic            seen_out,
	output logic            wr_out,
	output logic [2:0]      depth_out
);
	timeunit 1ns;
	timeprecision 1ps;
	int   aq[$];	// {error, ticks to wait, beats} per open address phase
	int   dq[$];	// beats still owed per acknowledged address
	int   pend;
	logic pace;
	// ************
	// bus side
	// ************
	always @(posedge clk_in) begin
		seen_out <= 1'h0;
		if (!resetn_in) begin
			aq.delete();
			dq.delete();
			pend = 0;
			pace <= 1'h0;
			{grant_n_out, other_bb_out} <= 2'h0;
			{addr_phase_ack_n_out, tea_n_out, ta_n_out} <= 3'h7;
		end else if (!tick_in) begin
			// bus clock rises here, so all outputs but seen_out move only on this edge; seen_out clears on the next
			{addr_phase_ack_n_out, tea_n_out, ta_n_out} <= 3'h7;
			grant_n_out <= hold_in;
			other_bb_out <= hold_in;
			pace <= ~pace;
			if (dq.size() > 0 && (!slow_in || pace)) begin
				ta_n_out <= 1'h0;
				dq[0]--;
				if (dq[0] == 0) begin
					void'(dq.pop_front());
					pend--;
				end
			end
			if (aq.size() > 0) begin
				if (aq[0][4:3] != 2'h0) begin
					aq[0] -= 8;
				end else if (aq[0][5]) begin
					tea_n_out <= 1'h0;
					void'(aq.pop_front());
					pend--;
				end else begin
					addr_phase_ack_n_out <= 1'h0;
					dq.push_back(aq.pop_front() % 8);
				end
			end
			if (!ts_n_in) begin
				seen_out <= 1'h1;
				wr_out <= write_in;
				depth_out <= 3'(pend);
				aq.push_back(int'({err_in, ack_dly_in, burst_n_in ? 3'h1 : 3'h4}));
				pend++;
			end
		end
	end
endmodule // ebm_bus_model

// ### test/testbench.sv
// self-checking bench of the external bus master against the far-side model
module testbench
	import ebm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_in, resetn_in, req_valid_in, req_ready_out, req_write_in, req_port16_in;
	logic        req_super_in, req_instr_in, req_burst_in, resp_valid_out, resp_error_out;
	logic        reservation_none_out, bus_clock_output_out, reset_indication_n_out, bus_request_n_out;
	logic        bus_grant_n_in, bus_busy_line_n_in, bus_busy_line_n_out, bus_busy_line_oe_out;
	logic        transfer_begin_n_out, write_out, burst_n_out, addr_phase_ack_n_in, addr_phase_retry_n_in;
	logic        bus_error_ack_n_in, beat_acknowledge_n_in, cancel_reservation_n_in;
	logic [31:0] req_addr_in;
	logic [29:0] addr_out, last_a;
	logic [3:0]  req_cycle_kind_in, cycle_kind_out, lane_select_n_out;
	logic [1:0]  address_space_type_out, ack_dly_in;
	ebm_size_t   req_size_in;
	logic        hold_in, err_in, slow_in, other_bb, ts_seen, ts_wr, ts_q, hold_busy;
	logic [2:0]  ts_depth;
	logic [41:0] cq[$];
	logic        hq[$], rq[$];
	int          error_cnt, tests_run, ts_cnt, run;
	logic [31:0] seed = 32'hD6EB;

	// nobody driving leaves the shared busy line at its pull-up
	assign bus_busy_line_n_in = ~((bus_busy_line_oe_out & ~bus_busy_line_n_out) | other_bb);

	ebm_master i_dut (.clk_in, .resetn_in, .req_valid_in, .req_ready_out, .req_addr_in, .req_write_in,
		.req_size_in, .req_port16_in, .req_super_in, .req_instr_in, .req_burst_in, .req_cycle_kind_in,
		.resp_valid_out, .resp_error_out, .reservation_none_out, .bus_clock_output_out,
		.reset_indication_n_out, .bus_request_n_out, .bus_grant_n_in, .bus_busy_line_n_in,
		.bus_busy_line_n_out, .bus_busy_line_oe_out, .addr_out, .transfer_begin_n_out, .write_out,
		.lane_select_n_out, .address_space_type_out, .cycle_kind_out, .burst_n_out, .addr_phase_ack_n_in,
		.addr_phase_retry_n_in, .bus_error_ack_n_in, .beat_acknowledge_n_in, .cancel_reservation_n_in);

	ebm_bus_model i_model (.clk_in, .resetn_in(reset_indication_n_out), .tick_in(bus_clock_output_out),
		.ts_n_in(transfer_begin_n_out),
		.burst_n_in(burst_n_out), .write_in(write_out), .hold_in, .err_in, .slow_in, .ack_dly_in,
		.grant_n_out(bus_grant_n_in), .other_bb_out(other_bb), .addr_phase_ack_n_out(addr_phase_ack_n_in),
		.tea_n_out(bus_error_ack_n_in), .ta_n_out(beat_acknowledge_n_in), .seen_out(ts_seen),
		.wr_out(ts_wr), .depth_out(ts_depth));

	// ************
	// helpers
	// ************
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_cyc(input logic [41:0] got, input logic [41:0] exp);
		chk(64'(got), 64'(exp));
	endtask

	task automatic wrap_up();
		$display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return (s >> 1) ^ (s[0] ? 32'h80200003 : 32'h0);
	endfunction

	// active-low lane pins of a 32-bit port, index 0 = most significant byte
	function automatic logic [3:0] lanes32(input logic [1:0] a, input ebm_size_t s);
		if (s == EBM_SZ_BYTE) return ~(4'h1 << a);
		if (s == EBM_SZ_HALF) return ~(4'h3 << {a[1], 1'b0});
		return 4'h0;
	endfunction

	task automatic issue(input logic [31:0] a, input logic w, input ebm_size_t sz, input logic p16,
		input logic sp, input logic ins, input logic bst, input logic [3:0] ck, input logic er);
		logic [3:0] ln;
		int         n;
		n = 0;
		ln = lanes32(a[1:0], sz);
		if (p16)
			ln = {sz == EBM_SZ_WORD, ~a[1], sz == EBM_SZ_BYTE ? ~(2'h1 << a[0]) : 2'h0};
		if (p16 && sz == EBM_SZ_WORD) begin
			// word to a narrow port goes out as two halves, bus kept between them
			cq.push_back({a[31:2], w, 4'hC, sp, ins, ck, ~bst});
			hq.push_back(1'h1);
			rq.push_back(er);
			ln = 4'h8;
		end
		cq.push_back({a[31:2], w, ln, sp, ins, ck, ~bst});
		hq.push_back(1'h0);
		rq.push_back(er);
		@(posedge clk_in);
		req_valid_in <= 1'h1;
		{req_addr_in, req_write_in, req_port16_in} <= {a, w, p16};
		req_size_in <= sz;
		{req_super_in, req_instr_in, req_burst_in, req_cycle_kind_in, err_in} <= {sp, ins, bst, ck, er};
		do begin
			@(posedge clk_in);
			n++;
		end while (req_ready_out !== 1'h1 && n < 4000);
		req_valid_in <= 1'h0;
		if (n >= 4000) chk(req_ready_out, 1);
	endtask

	task automatic wait_idle();
		int n;
		n = 0;
		while ((rq.size() > 0 || cq.size() > 0) && n < 4000) begin
			@(posedge clk_in);
			n++;
		end
		chk(n < 4000, 1);
		repeat (12) @(posedge clk_in);
	endtask

	// ************
	// bus monitor
	// ************
	always @(posedge clk_in) begin
		ts_q <= transfer_begin_n_out;
		if (resetn_in === 1'h1) begin
			if (transfer_begin_n_out === 1'h0 && ts_q === 1'h1) begin
				ts_cnt++;
				run = 1;
				chk(bus_busy_line_oe_out & ~bus_busy_line_n_out, 1);
				chk({bus_grant_n_in, other_bb}, 0);
				if (cq.size() == 0) begin
					chk(1, 0);
				end else begin
					chk_cyc({addr_out, write_out, lane_select_n_out, address_space_type_out,
						cycle_kind_out, burst_n_out}, cq.pop_front());
					hold_busy = hq.pop_front();
				end
				last_a = addr_out;
			end else if (transfer_begin_n_out === 1'h0) begin
				run++;
			end else if (ts_q === 1'h0) begin
				chk(run, 2);
				chk(addr_out, last_a);
			end
			if (hold_busy && bus_busy_line_oe_out !== 1'h1) chk(bus_busy_line_oe_out, 1);
			if (ts_seen) chk(ts_depth <= (ts_wr ? 3'h0 : 3'h1), 1);
			if (resp_valid_out === 1'h1) begin
				if (rq.size() == 0) chk(1, 0);
				else chk(resp_error_out, rq.pop_front());
			end
		end
	end

	initial begin
		clk_in = 1'h0;
		forever #4 clk_in = ~clk_in;
	end

	initial begin
		repeat (60000) @(posedge clk_in);
		error_cnt++;
		wrap_up();
	end

	// ************
	// scenarios
	// ************
	initial begin
		logic [31:0] a;
		ebm_size_t   sz;
		int          n;
		{resetn_in, req_valid_in, req_write_in, req_port16_in, req_super_in, req_instr_in} = 6'h0;
		{req_burst_in, hold_in, err_in, slow_in, ts_q, hold_busy} = 6'h1;
		{req_addr_in, req_cycle_kind_in, ack_dly_in} = '0;
		{req_burst_in, hold_busy} = 2'h0;
		req_size_in = EBM_SZ_WORD;
		{cancel_reservation_n_in, addr_phase_retry_n_in} = 2'h3;
		repeat (20) @(posedge clk_in);
		chk(reset_indication_n_out, 0);
		chk({bus_request_n_out, bus_busy_line_oe_out}, 2);
		resetn_in <= 1'h1;
		repeat (4) @(posedge clk_in);
		chk(reset_indication_n_out, 1);
		cancel_reservation_n_in <= 1'h0;
		repeat (6) @(posedge clk_in);
		chk(reservation_none_out, 1);
		cancel_reservation_n_in <= 1'h1;
		// mixed sizes, ports and directions, back to back
		for (int i = 0; i < 24; i++) begin
			seed = lfsr(seed);
			sz = ebm_size_t'(seed[1:0] == 2'h3 ? 2'h2 : seed[1:0]);
			a = seed ^ {seed[15:0], seed[31:16]};
			if (sz != EBM_SZ_BYTE) a[0] = 1'h0;
			if (sz == EBM_SZ_WORD) a[1] = 1'h0;
			ack_dly_in <= seed[13:12];
			slow_in <= seed[14];
			issue(a, seed[5], sz, seed[4], seed[6], seed[7], 1'h0, seed[11:8], 1'h0);
		end
		wait_idle();
		// slow data with reads piling up, bursts among them, then a write
		slow_in <= 1'h1;
		ack_dly_in <= 2'h0;
		for (int i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			issue({seed[31:2], 2'h0}, i == 5, EBM_SZ_WORD, 1'h0, i[1], i[0], i[0] && i < 5, seed[11:8],
				1'h0);
		end
		wait_idle();
		// rival owner holds the bus
		hold_in <= 1'h1;
		repeat (8) @(posedge clk_in);
		n = ts_cnt;
		issue(32'h00001000, 1'h1, EBM_SZ_WORD, 1'h0, 1'h1, 1'h0, 1'h0, 4'h5, 1'h0);
		repeat (40) @(posedge clk_in);
		chk(bus_request_n_out, 0);
		chk(ts_cnt == n, 1);
		hold_in <= 1'h0;
		wait_idle();
		chk(bus_busy_line_oe_out, 0);
		// address phase ended by an error acknowledge
		issue(32'h00002004, 1'h0, EBM_SZ_WORD, 1'h0, 1'h0, 1'h1, 1'h0, 4'hA, 1'h1);
		wait_idle();
		err_in <= 1'h0;
		chk(bus_busy_line_oe_out, 0);
		wrap_up();
	end
endmodule // testbench
